/* design/serial_port_pkg.sv */
// Behaviour
// - self-clocked, select low: first data bit driven within two master periods of ready.
// - self-clocked, ready low: data driven within two master periods of select falling.
// - self-clocked: most significant bit stands one master period before first clock rise.
// - self-clocked: generated clock high and low phases each last one master period.
// - self-clocked: data moves to the next bit after each falling generated clock edge.
// - self-clocked: data floats one master period after the last rising clock edge.
// - self-clocked, select released early: finish the bit in progress, then float data and clock.
// - self-clocked: outputs float within two master periods after select rises.
// - select is only recognised while ready is low; recognition may lag slightly.
// - externally clocked: valid data within 200 ns after select falls.
// - externally clocked: data changes only on falling edges of the host clock.
// - externally clocked: one rising edge arms shifting; earlier falling edges are ignored.
// - externally clocked: data floats after the falling edge that follows the last bit.
package serial_port_pkg;

  // ****************************************
  // word layout
  // ****************************************
  localparam int WORD_W = 20;
  localparam int BIT_W = 5;
  localparam int NARROW_PAD = 4;
  localparam logic [BIT_W-1:0] LAST_WIDE = 5'h13;
  localparam logic [BIT_W-1:0] LAST_NARROW = 5'h0f;
  localparam int BUF_DEPTH = 2;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_CLK_HZ = 250_000_000;
  localparam int MCLK_HZ = 32_768;
  localparam int MCLK_CYC_DFLT = SYS_CLK_HZ / MCLK_HZ;
  localparam int DIV_W = 16;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [2:0] SYNC_HIGH_RST = 3'h7;
  localparam logic [2:0] SYNC_LOW_RST = 3'h0;
  localparam logic RDY_N_RST = 1'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_HIGH,
    ST_LOW,
    ST_EXT
  } port_state_t;

endpackage : serial_port_pkg

/* design/word_buffer.sv */
module word_buffer #(
  parameter int WIDTH = serial_port_pkg::WORD_W,
  parameter int DEPTH = serial_port_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import serial_port_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic in_rdy;
  } buf_t;

  buf_t q_r;
  buf_t q_nxt;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : wrap_inc

  assign push = in_valid & q_r.in_rdy;
  assign pop = out_ready & out_valid;
  assign in_ready = q_r.in_rdy;
  assign out_valid = (q_r.cnt != '0);
  assign out_data = q_r.mem[q_r.rp];

  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wp] = in_data;
      q_nxt.wp = wrap_inc(q_r.wp);
    end
    if (pop) begin
      q_nxt.rp = wrap_inc(q_r.rp);
    end
    case ({push, pop})
      2'b10: q_nxt.cnt = q_r.cnt + (PW+1)'(1);
      2'b01: q_nxt.cnt = q_r.cnt - (PW+1)'(1);
      default: q_nxt.cnt = q_r.cnt;
    endcase
    // ready is registered so the source sees a clean flop; it may lag a pop by one cycle
    q_nxt.in_rdy = (q_nxt.cnt != (PW+1)'(DEPTH));
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q_r <= '{in_rdy: 1'b1, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule : word_buffer

/* design/result_port.sv */
module result_port #(
  parameter int MCLK_CYC = serial_port_pkg::MCLK_CYC_DFLT
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // finished conversion words
  input wire logic [serial_port_pkg::WORD_W-1:0] conv_data,
  input wire logic conv_valid,
  output logic conv_ready,
  input wire logic wide_word,
  // mode strap and select
  input wire logic port_mode_sleep_pin,
  input wire logic select_n,
  // host serial clock, used in externally clocked mode
  input wire logic link_clk,
  // serial pins
  output logic serial_result_out,
  output logic serial_result_oe,
  output logic serial_clk_out,
  output logic serial_clk_oe,
  output logic result_ready_n
);
  import serial_port_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    port_state_t st;
    logic [2:0] cs_s;
    logic [2:0] mode_s;
    logic [2:0] rise_s;
    logic [2:0] fall_s;
    logic cs_low;
    logic self_clocked_mode;
    logic rise_lvl;
    logic fall_lvl;
    logic [DIV_W-1:0] div;
    logic [WORD_W-1:0] word;
    logic [BIT_W-1:0] bits;
    logic [BIT_W-1:0] last;
    logic armed;
    logic pop;
    logic sdo;
    logic sdo_oe;
    logic sclk;
    logic sclk_oe;
    logic rdy_n;
  } sys_t;

  typedef struct packed {
    logic tog;
  } link_t;

  localparam sys_t SYS_RST = '{
    st: ST_IDLE,
    cs_s: SYNC_HIGH_RST,
    mode_s: SYNC_LOW_RST,
    rdy_n: RDY_N_RST,
    default: '0
  };

  sys_t q_r;
  sys_t q_nxt;
  link_t rise_r;
  link_t rise_nxt;
  link_t fall_r;
  link_t fall_nxt;

  logic [WORD_W-1:0] buf_data;
  logic buf_valid;
  logic tick;
  logic rise_ev;
  logic fall_ev;
  logic recognised;

  // ****************************************
  // helpers
  // ****************************************

  // a synchronised level moves only once the second and third stages agree
  function automatic logic settle(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction : settle

  // narrow words are left-justified so the top bit always leaves first
  function automatic logic [WORD_W-1:0] justify(input logic [WORD_W-1:0] d, input logic wide);
    return wide ? d : {d[WORD_W-NARROW_PAD-1:0], NARROW_PAD'(0)};
  endfunction : justify

  function automatic sys_t floated(input sys_t x);
    sys_t y;
    y = x;
    y.sdo_oe = 1'b0;
    y.sclk_oe = 1'b0;
    y.sclk = 1'b0;
    y.st = ST_IDLE;
    return y;
  endfunction : floated

  function automatic sys_t shifted(input sys_t x);
    sys_t y;
    y = x;
    y.word = {x.word[WORD_W-2:0], 1'b0};
    y.sdo = x.word[WORD_W-2];
    y.bits = x.bits + BIT_W'(1);
    return y;
  endfunction : shifted

  // ****************************************
  // result buffer
  // ****************************************

  // two words of slack so a slow reader never loses a finished conversion
  word_buffer #(
    .WIDTH(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_data(conv_data),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(q_r.pop)
  );

  // ****************************************
  // link domain
  // ****************************************

  // each host clock edge flips a toggle; the system side turns flips into events
  always_comb begin
    rise_nxt.tog = ~rise_r.tog;
    fall_nxt.tog = ~fall_r.tog;
  end

  always_ff @(posedge link_clk) begin
    if (!resetn) begin
      rise_r <= '0;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  always_ff @(negedge link_clk) begin
    if (!resetn) begin
      fall_r <= '0;
    end else begin
      fall_r <= fall_nxt;
    end
  end

  // ****************************************
  // system domain
  // ****************************************
  assign tick = (q_r.div == DIV_W'(MCLK_CYC - 1));
  // events come from registered stages only, so they never feed back into the process that reads them
  assign rise_ev = (settle(q_r.rise_s, q_r.rise_lvl) != q_r.rise_lvl);
  assign fall_ev = (settle(q_r.fall_s, q_r.fall_lvl) != q_r.fall_lvl);
  // a select seen while the ready flag is high waits until the flag falls
  assign recognised = q_r.cs_low & ~q_r.rdy_n & ~q_r.pop;

  always_comb begin
    q_nxt = q_r;
    q_nxt.pop = 1'b0;
    q_nxt.cs_s = {q_r.cs_s[1:0], select_n};
    q_nxt.mode_s = {q_r.mode_s[1:0], port_mode_sleep_pin};
    q_nxt.rise_s = {q_r.rise_s[1:0], rise_r.tog};
    q_nxt.fall_s = {q_r.fall_s[1:0], fall_r.tog};
    q_nxt.cs_low = ~settle(q_r.cs_s, ~q_r.cs_low);
    q_nxt.self_clocked_mode = settle(q_r.mode_s, q_r.self_clocked_mode);
    q_nxt.rise_lvl = settle(q_r.rise_s, q_r.rise_lvl);
    q_nxt.fall_lvl = settle(q_r.fall_s, q_r.fall_lvl);
    q_nxt.div = tick ? '0 : q_r.div + DIV_W'(1);

    unique case (q_r.st)
      ST_IDLE: begin
        if (recognised) begin
          // msb goes out at once, well inside the access window
          q_nxt.word = justify(buf_data, wide_word);
          q_nxt.last = wide_word ? LAST_WIDE : LAST_NARROW;
          q_nxt.bits = '0;
          q_nxt.sdo = q_nxt.word[WORD_W-1];
          q_nxt.sdo_oe = 1'b1;
          q_nxt.sclk = 1'b0;
          q_nxt.sclk_oe = q_r.self_clocked_mode;
          q_nxt.div = '0;
          q_nxt.armed = 1'b0;
          // mode is frozen for the whole word
          q_nxt.st = q_r.self_clocked_mode ? ST_LEAD : ST_EXT;
        end
      end

      ST_LEAD: begin
        // the msb is already a bit in progress, so it is clocked out even after a release
        if (tick) begin
          q_nxt.sclk = 1'b1;
          q_nxt.st = ST_HIGH;
        end
      end

      ST_HIGH: begin
        if (tick) begin
          q_nxt.sclk = 1'b0;
          if (q_r.bits == q_r.last) begin
            // falling edge is one master period after the last rise
            q_nxt = floated(q_nxt);
            q_nxt.pop = 1'b1;
          end else if (!q_r.cs_low) begin
            // bit just completed; the word stays in the buffer
            q_nxt = floated(q_nxt);
          end else begin
            q_nxt = shifted(q_nxt);
            q_nxt.st = ST_LOW;
          end
        end
      end

      ST_LOW: begin
        // a presented bit always gets its rising edge; the release is honoured after it
        if (tick) begin
          q_nxt.sclk = 1'b1;
          q_nxt.st = ST_HIGH;
        end
      end

      ST_EXT: begin
        if (!q_r.cs_low) begin
          // the host ends its bit with its own falling edge before release
          q_nxt = floated(q_nxt);
        end else begin
          if (fall_ev && q_r.armed) begin
            if (q_r.bits == q_r.last) begin
              q_nxt = floated(q_nxt);
              q_nxt.pop = 1'b1;
            end else begin
              q_nxt = shifted(q_nxt);
            end
          end
          if (rise_ev) begin
            q_nxt.armed = 1'b1;
          end
        end
      end
    endcase

    // ready goes high for at least the pop cycles, then follows the buffer
    q_nxt.rdy_n = ~buf_valid | q_nxt.pop | q_r.pop;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q_r <= SYS_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************
  // pins
  // ****************************************
  assign serial_result_out = q_r.sdo;
  assign serial_result_oe = q_r.sdo_oe;
  assign serial_clk_out = q_r.sclk;
  assign serial_clk_oe = q_r.sclk_oe;
  assign result_ready_n = q_r.rdy_n;

endmodule : result_port

/* bench/result_port_monitor.sv */
module result_port_monitor #(
  parameter int MCLK_CYC = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // strap, select and host clock
  input wire logic port_mode_sleep_pin,
  input wire logic select_n,
  input wire logic link_clk,
  // serial pins and ready flag
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic serial_clk_out,
  input wire logic serial_clk_oe,
  input wire logic result_ready_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // phase length of the generated clock
  // ****************************************
  logic [7:0] run_r;
  logic last_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge sys_clk) begin
    last_r <= serial_clk_out;
    if (!serial_clk_oe) run_r <= 8'h00;
    else if (serial_clk_out != last_r) run_r <= 8'h01;
    else run_r <= run_r + 8'h01;
  end
  // ****************************************
  // checks
  // ****************************************
  property p_start;
    $rose(serial_result_oe) |-> !result_ready_n && !$past(select_n, 3);
  endproperty
  a_start: assert property (p_start) else $error("frame began without ready and select");
  property p_sel;
    ($fell(select_n) && !result_ready_n && port_mode_sleep_pin) |-> ##[1:8] serial_result_oe;
  endproperty
  a_sel: assert property (p_sel) else $error("data late after select fell");
  property p_rdy;
    ($fell(result_ready_n) && !select_n && port_mode_sleep_pin) |-> ##[1:8] serial_result_oe;
  endproperty
  a_rdy: assert property (p_rdy) else $error("data late after ready fell");
  property p_phase;
    (serial_clk_oe && serial_clk_out != last_r) |-> run_r == MCLK_CYC;
  endproperty
  a_phase: assert property (p_phase) else $error("clock phase length wrong");
  property p_shift;
    (serial_clk_oe && $past(serial_clk_oe) && serial_result_oe && $past(serial_result_oe)
      && $changed(serial_result_out)) |-> $fell(serial_clk_out);
  endproperty
  a_shift: assert property (p_shift) else $error("data moved off a falling clock");
  property p_float;
    ($fell(serial_result_oe) && $past(serial_clk_oe)) |-> $past(serial_clk_out);
  endproperty
  a_float: assert property (p_float) else $error("data floated before bit end");
  property p_pair;
    $fell(serial_clk_oe) |-> $fell(serial_result_oe);
  endproperty
  a_pair: assert property (p_pair) else $error("clock and data floated apart");
  property p_rel;
    ($rose(select_n) && port_mode_sleep_pin) |-> ##[1:16] !serial_result_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("outputs still driven after select rose");
  property p_ext;
    (!port_mode_sleep_pin && !serial_clk_oe && $past(serial_result_oe)
      && (!serial_result_oe || $changed(serial_result_out))) |-> !link_clk;
  endproperty
  a_ext: assert property (p_ext) else $error("data moved while host clock high");
endmodule : result_port_monitor

/* bench/host_model.sv */
module host_model
  import serial_port_pkg::*;
(
  // serial pins from the port
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic serial_clk_out,
  input wire logic serial_clk_oe,
  // host clock and captured word
  output logic link_clk,
  output logic [WORD_W-1:0] word
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk = 1'b0;
    word = 20'h0;
    // two edges inside reset so the link-side toggles start defined
    #8 link_clk = 1'b1;
    #8 link_clk = 1'b0;
  end
  always @(posedge serial_clk_out) begin
    if (serial_clk_oe && serial_result_oe) word = {word[WORD_W-2:0], serial_result_out};
  end
  task automatic ext_frame(input int nbits);
    #300;
    repeat (nbits) begin
      link_clk = 1'b1;
      word = {word[WORD_W-2:0], serial_result_out & serial_result_oe};
      // phases run shorter than a real host may use; the port needs only a few system cycles each
      #62.5 link_clk = 1'b0;
      #62.5;
    end
  endtask : ext_frame
endmodule : host_model

/* bench/result_port_tb.sv */
module result_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_port_pkg::*;
  localparam int P = 4;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [WORD_W-1:0] conv_data = 20'h0;
  logic conv_valid = 1'b0;
  logic wide_word = 1'b1;
  logic port_mode_sleep_pin = 1'b1;
  logic select_n = 1'b1;
  logic conv_ready, link_clk, serial_result_out, serial_result_oe;
  logic serial_clk_out, serial_clk_oe, result_ready_n;
  logic [WORD_W-1:0] seen;
  int err_count = 0;
  int n_tests = 0;
  always #2 sys_clk = ~sys_clk;
  result_port #(.MCLK_CYC(P)) i_result_port (.sys_clk, .resetn, .conv_data, .conv_valid, .conv_ready,
    .wide_word, .port_mode_sleep_pin, .select_n, .link_clk, .serial_result_out, .serial_result_oe,
    .serial_clk_out, .serial_clk_oe, .result_ready_n);
  host_model i_host_model (.serial_result_out, .serial_result_oe, .serial_clk_out, .serial_clk_oe,
    .link_clk, .word(seen));
  // ****************************************
  // helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic check(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic push(input logic [WORD_W-1:0] w);
    conv_data = w;
    conv_valid = 1'b1;
    for (int i = 0; i < 400 && conv_ready !== 1'b1; i++) step(1);
    check("conv_ready at take", 20'h1, WORD_W'(conv_ready));
    step(1);
    conv_valid = 1'b0;
    // one edge with valid low keeps back-to-back pushes apart
    step(1);
  endtask : push
  // waits for a frame to end with its word consumed
  task automatic done();
    step(4);
    for (int i = 0; i < 600 && !(serial_result_oe === 1'b0 && result_ready_n === 1'b1); i++) step(1);
    check("frame end", 20'h1, WORD_W'(serial_result_oe === 1'b0 && result_ready_n === 1'b1));
  endtask : done
  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_self();
    select_n = 1'b0;
    push(20'h9a5c3);
    push(20'h36e1f);
    step(3);
    check("conv_ready full", 20'h0, WORD_W'(conv_ready));
    done();
    check("first word", 20'h9a5c3, seen);
    done();
    check("second word", 20'h36e1f, seen);
    wide_word = 1'b0;
    push(20'hb4d2c);
    done();
    check("narrow word", 20'h04d2c, {4'h0, seen[15:0]});
    wide_word = 1'b1;
    select_n = 1'b1;
    step(4);
  endtask : t_self
  task automatic t_early();
    push(20'h5e0a7);
    select_n = 1'b0;
    step(30);
    select_n = 1'b1;
    step(20);
    check("oe after early release", 20'h0, WORD_W'(serial_result_oe));
    check("ready kept", 20'h0, WORD_W'(result_ready_n));
    select_n = 1'b0;
    done();
    check("restarted word", 20'h5e0a7, seen);
    select_n = 1'b1;
    step(4);
  endtask : t_early
  task automatic t_ext();
    port_mode_sleep_pin = 1'b0;
    step(8);
    push(20'hc3b69);
    select_n = 1'b0;
    step(40);
    check("oe in external mode", 20'h1, WORD_W'(serial_result_oe));
    check("clock oe in external mode", 20'h0, WORD_W'(serial_clk_oe));
    i_host_model.ext_frame(20);
    step(8);
    check("external word", 20'hc3b69, seen);
    check("oe after last fall", 20'h0, WORD_W'(serial_result_oe));
    check("ready after pop", 20'h1, WORD_W'(result_ready_n));
    select_n = 1'b1;
  endtask : t_ext
  initial begin
    step(12);
    resetn = 1'b1;
    step(6);
    t_self();
    t_early();
    t_ext();
    print_verdict();
  end
  initial begin
    #40000;
    err_count++;
    print_verdict();
  end
endmodule : result_port_tb
bind result_port result_port_monitor #(.MCLK_CYC(MCLK_CYC)) i_result_port_monitor (.sys_clk, .resetn,
  .port_mode_sleep_pin, .select_n, .link_clk, .serial_result_out, .serial_result_oe, .serial_clk_out,
  .serial_clk_oe, .result_ready_n);
